// [hw/usart_cfg.svh]
`ifndef USART_CFG_SVH
`define USART_CFG_SVH

// system clock period in ns (20 MHz)
`define SYS_CLK_NS 50
// baud divisor width and range 0..4095
`define BAUD_W 12
// divisions per bit in the asynchronous modes, as last-state values
`define DIV_NORMAL_TOP 4'hF
`define DIV_DOUBLE_TOP 4'h7
// sample point inside an asynchronous bit
`define MID_NORMAL 4'h8
`define MID_DOUBLE 4'h4
// character size selection
`define SIZE_NINE 3'h7
`define SIZE_BASE 4'h5
`define SIZE_DEFAULT 4'h8
// parity mode field positions
`define PAR_EN_BIT 1
`define PAR_ODD_BIT 0
// idle line level
`define LINE_IDLE 1'b1
// receive buffer depth
`define RX_DEPTH 2'h2

`endif

// [hw/usart_core.sv]
`timescale 1ns/1ns
`include "usart_cfg.svh"
// Summary of operation
// - four clock modes; sync_mode_select picks asynchronous or synchronous.
// - in synchronous mode the clock pin direction picks master or slave clock.
// - transfer clock pin is used only in synchronous mode.
// - baud counter reloads at zero and when the low divisor byte is written.
// - one baud pulse per zero, rate is clock over divisor plus one.
// - bit rate divides baud pulses by 16, 8 or 2 in normal, double speed and sync master modes; slave follows the pin.
// - divisor is 12 bits, high nibble joined to low byte.
// - double speed acts only in asynchronous mode; software keeps it clear otherwise.
// - double speed makes the receiver use 8 samples per bit.
// - slave clock passes a sync register and edge detector, two cycles late.
// - synchronous receive samples on the edge opposite the transmit change edge.
// - polarity zero changes on rising and samples on falling, else reversed.
// - one start, 5 to 9 data, none/even/odd parity, 1 or 2 stops.
// - order is start, data lsb first, parity, stop bits.
// - after stops the line carries a new start bit or idles high.
// - transmitter and receiver share one frame format setting.
// - receiver checks only the first stop bit for the frame error.
// - parity is xor of data bits, inverted for odd.
// - one write buffer before the shifter allows gapless frames.
// - two-level receive buffer with frame, overrun and parity errors.
// - shifter loads the buffer when idle or right after the last stop bit.
// - software writes the ninth bit before the low data byte.
// - unused upper data bits are ignored for short characters.
module usart_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // mode and frame format
    input wire logic sync_mode_select,
    input wire logic double_speed,
    input wire logic xfer_clock_pin_dir,
    input wire logic sync_clock_polarity,
    input wire usart_pkg::frame_cfg_t frame_cfg,
    // baud divisor
    input wire logic [3:0] baud_divisor_high,
    input wire logic [7:0] baud_divisor_low,
    input wire logic baud_low_wr,
    // transmit side
    input wire logic [7:0] tx_data,
    input wire logic ninth_tx_bit,
    input wire logic tx_wr,
    output logic tx_buf_empty,
    output logic tx_done,
    // receive side
    input wire logic rx_rd,
    output logic [8:0] rx_data,
    output logic rx_valid,
    output logic frame_error_flag,
    output logic parity_error_flag,
    output logic overrun_flag,
    // serial pins
    output logic serial_tx_pin,
    input wire logic serial_rx_pin,
    input wire logic transfer_clock_pin_in,
    output logic transfer_clock_pin_out,
    output logic transfer_clock_pin_oe
);
    import usart_pkg::*;

    state_t st_reg;
    state_t st_next;

    function automatic logic [3:0] char_bits(input logic [2:0] sel);
        if (sel == `SIZE_NINE) begin
            char_bits = 4'h9;
        end else if (sel[2] == 1'b0) begin
            char_bits = `SIZE_BASE + {2'h0, sel[1:0]};
        end else begin
            char_bits = `SIZE_DEFAULT;
        end
    endfunction

    function automatic frame_t build_frame(input logic [8:0] d, input frame_cfg_t c);
        logic [3:0] n;
        logic p;
        frame_t f;
        n = char_bits(c.char_size_sel);
        p = c.parity_mode_sel[`PAR_ODD_BIT];
        f.bits = '1;
        f.bits[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                f.bits[i + 1] = d[i];
                p = p ^ d[i];
            end
        end
        if (c.parity_mode_sel[`PAR_EN_BIT]) begin
            f.bits[n + 4'h1] = p;
        end
        f.len = n + 4'h2 + {3'h0, c.parity_mode_sel[`PAR_EN_BIT]} + {3'h0, c.stop_bits_sel};
        build_frame = f;
    endfunction

    logic sync_m;
    logic master_m;
    logic slave_m;
    logic tick;
    logic [3:0] top;
    logic [3:0] mid;
    logic xrise;
    logic xfall;
    logic chg_edge;
    logic smp_edge;
    logic tx_step;
    logic rx_smp;
    logic push;
    logic pop;
    logic [3:0] nbits;
    logic pen;
    rx_entry_t ent;
    frame_t fr;

    always_comb begin
        st_next = st_reg;
        st_next.tdone = 1'b0;
        sync_m = sync_mode_select;
        master_m = sync_m && xfer_clock_pin_dir;
        slave_m = sync_m && !xfer_clock_pin_dir;
        st_next.xoe = master_m;
        nbits = char_bits(frame_cfg.char_size_sel);
        pen = frame_cfg.parity_mode_sel[`PAR_EN_BIT];
        // baud down-counter
        tick = (st_reg.cnt == 12'h000);
        if (baud_low_wr) begin
            st_next.cnt = {baud_divisor_high, baud_divisor_low};
        end else if (tick) begin
            st_next.cnt = {baud_divisor_high, baud_divisor_low};
        end else begin
            st_next.cnt = st_reg.cnt - 12'h001;
        end
        // per-bit division, double speed only when asynchronous
        top = (double_speed && !sync_m) ? `DIV_DOUBLE_TOP : `DIV_NORMAL_TOP;
        mid = (double_speed && !sync_m) ? `MID_DOUBLE : `MID_NORMAL;
        // transfer clock: master toggles per baud pulse, slave is synchronised
        st_next.xck = master_m ? (st_reg.xck ^ tick) : 1'b0;
        st_next.x1 = transfer_clock_pin_in;
        st_next.x2 = st_reg.x1;
        st_next.x3 = st_reg.x2;
        if (master_m) begin
            xrise = tick && !st_reg.xck;
            xfall = tick && st_reg.xck;
        end else begin
            xrise = slave_m && st_reg.x2 && !st_reg.x3;
            xfall = slave_m && !st_reg.x2 && st_reg.x3;
        end
        chg_edge = sync_clock_polarity ? xfall : xrise;
        smp_edge = sync_clock_polarity ? xrise : xfall;
        // transmit prescaler
        if (!sync_m && tick) begin
            st_next.tpre = (st_reg.tpre == top) ? 4'h0 : st_reg.tpre + 4'h1;
        end
        tx_step = sync_m ? chg_edge : (tick && st_reg.tpre == top);
        // transmitter
        fr = build_frame(st_reg.tbuf, frame_cfg);
        if (tx_step) begin
            if (st_reg.tleft != 4'h0) begin
                st_next.txd = st_reg.tsh[0];
                st_next.tsh = {1'b1, st_reg.tsh[12:1]};
                st_next.tleft = st_reg.tleft - 4'h1;
            end else if (st_reg.tfull) begin
                st_next.txd = fr.bits[0];
                st_next.tsh = {1'b1, fr.bits[12:1]};
                st_next.tleft = fr.len - 4'h1;
                st_next.tfull = 1'b0;
                st_next.tbusy = 1'b1;
            end else begin
                st_next.txd = `LINE_IDLE;
                st_next.tdone = st_reg.tbusy;
                st_next.tbusy = 1'b0;
            end
        end
        if (tx_wr && !st_reg.tfull) begin
            st_next.tbuf = {ninth_tx_bit, tx_data};
            st_next.tfull = 1'b1;
        end
        // receiver clock recovery
        rx_smp = sync_m ? smp_edge : 1'b0;
        if (!sync_m && tick) begin
            if (!st_reg.ract) begin
                st_next.ract = !serial_rx_pin;
                st_next.rph = 4'h1;
            end else begin
                st_next.rph = (st_reg.rph == top) ? 4'h0 : st_reg.rph + 4'h1;
                rx_smp = (st_reg.rph == mid);
            end
        end
        // receive frame
        push = 1'b0;
        ent = '0;
        if (rx_smp) begin
            unique case (st_reg.rstate)
                RX_IDLE: begin
                    if (!serial_rx_pin) begin
                        st_next.rstate = RX_DATA;
                        st_next.ridx = 4'h0;
                        st_next.rdat = '0;
                        st_next.rpar = 1'b0;
                    end else begin
                        st_next.ract = 1'b0;
                    end
                end
                RX_DATA: begin
                    st_next.rdat[st_reg.ridx] = serial_rx_pin;
                    st_next.rpar = st_reg.rpar ^ serial_rx_pin;
                    st_next.ridx = st_reg.ridx + 4'h1;
                    if (st_reg.ridx == nbits - 4'h1) begin
                        st_next.rstate = pen ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    st_next.rpar = st_reg.rpar ^ serial_rx_pin
                        ^ frame_cfg.parity_mode_sel[`PAR_ODD_BIT];
                    st_next.rstate = RX_STOP;
                end
                RX_STOP: begin
                    push = 1'b1;
                    ent.frm_err = !serial_rx_pin;
                    ent.pe = pen && st_reg.rpar;
                    ent.data = st_reg.rdat;
                    st_next.rstate = RX_IDLE;
                    st_next.ract = 1'b0;
                end
            endcase
        end
        // two-level receive buffer
        pop = rx_rd && (st_reg.rcnt != 2'h0);
        if (pop) begin
            st_next.q0 = st_reg.q1;
            st_next.ovr = 1'b0;
        end
        if (push && st_reg.rcnt == `RX_DEPTH && !pop) begin
            st_next.ovr = 1'b1;
        end else if (push) begin
            if ((st_reg.rcnt - {1'b0, pop}) == 2'h0) begin
                st_next.q0 = ent;
            end else begin
                st_next.q1 = ent;
            end
        end
        st_next.rcnt = st_reg.rcnt + {1'b0, push && !(st_reg.rcnt == `RX_DEPTH && !pop)}
            - {1'b0, pop};
        st_next.rvalid = (st_next.rcnt != 2'h0);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.txd <= `LINE_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign serial_tx_pin = st_reg.txd;
    assign transfer_clock_pin_out = st_reg.xck;
    assign transfer_clock_pin_oe = st_reg.xoe;
    assign tx_buf_empty = !st_reg.tfull;
    assign tx_done = st_reg.tdone;
    assign rx_data = st_reg.q0.data;
    assign rx_valid = st_reg.rvalid;
    assign frame_error_flag = st_reg.q0.frm_err;
    assign parity_error_flag = st_reg.q0.pe;
    assign overrun_flag = st_reg.ovr;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence slave_rise_s;
        slave_m && !transfer_clock_pin_in ##1 (slave_m && transfer_clock_pin_in) [*3];
    endsequence

    sequence held_div_s;
        !baud_low_wr && st_reg.cnt == 12'h000;
    endsequence

    baud_reload_a: assert property (held_div_s |=>
        st_reg.cnt == {$past(baud_divisor_high), $past(baud_divisor_low)})
        else $error("baud counter did not reload at zero");
    low_write_a: assert property (baud_low_wr |=>
        st_reg.cnt == {$past(baud_divisor_high), $past(baud_divisor_low)})
        else $error("low divisor write did not reload counter");
    count_down_a: assert property ((!baud_low_wr && st_reg.cnt != 12'h000) |=>
        st_reg.cnt == $past(st_reg.cnt) - 12'h001)
        else $error("baud counter did not count down");
    slave_edge_a: assert property (slave_rise_s |-> xrise)
        else $error("slave clock edge not seen two cycles late");
    clock_oe_a: assert property (##1 transfer_clock_pin_oe ==
        ($past(sync_mode_select) && $past(xfer_clock_pin_dir)))
        else $error("clock pin direction wrong");
    idle_line_a: assert property (!st_reg.tbusy |-> serial_tx_pin)
        else $error("line not idle high");
    start_bit_a: assert property ($rose(st_reg.tbusy) |-> !serial_tx_pin)
        else $error("frame did not open with start bit");
    rx_depth_a: assert property (st_reg.rcnt <= `RX_DEPTH)
        else $error("receive buffer over two entries");
    overrun_set_a: assert property ((push && st_reg.rcnt == `RX_DEPTH && !pop) |=>
        overrun_flag && rx_valid)
        else $error("overrun not flagged");
    async_div_a: assert property ((!sync_m && tx_step) |=>
        st_reg.tpre == 4'h0)
        else $error("transmit bit division wrong");

endmodule // usart_core

// [hw/usart_pkg.sv]
package usart_pkg;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_DATA = 2'h1,
        RX_PAR = 2'h3,
        RX_STOP = 2'h2
    } rx_state_t;

    typedef struct packed {
        logic [2:0] char_size_sel;
        logic [1:0] parity_mode_sel;
        logic stop_bits_sel;
    } frame_cfg_t;

    typedef struct packed {
        logic frm_err;
        logic pe;
        logic [8:0] data;
    } rx_entry_t;

    typedef struct packed {
        logic [12:0] bits;
        logic [3:0] len;
    } frame_t;

    typedef struct packed {
        logic [11:0] cnt;
        logic xck;
        logic xoe;
        logic x1;
        logic x2;
        logic x3;
        logic [3:0] tpre;
        logic [12:0] tsh;
        logic [3:0] tleft;
        logic tbusy;
        logic [8:0] tbuf;
        logic tfull;
        logic txd;
        logic tdone;
        logic ract;
        logic [3:0] rph;
        rx_state_t rstate;
        logic [3:0] ridx;
        logic [8:0] rdat;
        logic rpar;
        rx_entry_t q0;
        rx_entry_t q1;
        logic [1:0] rcnt;
        logic rvalid;
        logic ovr;
    } state_t;

endpackage

// [verif/test_usart_core.sv]
`timescale 1ns/1ns
module test_usart_core;
    import usart_pkg::*;
    logic sys_clk, rst_b, sync_mode_select, double_speed, xfer_clock_pin_dir, sync_clock_polarity;
    logic baud_low_wr, ninth_tx_bit, tx_wr, tx_buf_empty, tx_done, rx_rd, rx_valid;
    logic frame_error_flag, parity_error_flag, overrun_flag, serial_tx_pin, serial_rx_pin;
    logic transfer_clock_pin_in, transfer_clock_pin_out, transfer_clock_pin_oe, hold_rd, prev;
    logic [3:0] baud_divisor_high;
    logic [7:0] baud_divisor_low, tx_data;
    logic [8:0] rx_data;
    logic [10:0] got_frame, e;
    logic got_valid;
    logic [10:0] tx_exp[$], rx_exp[$];
    frame_cfg_t frame_cfg;
    logic [2:0] sizes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [1:0] pars [3] = '{2'h0, 2'h2, 2'h3};
    int failures, cmp_count, seed, bit_cyc, nbits, i, j, k, s, p, sp, ds;
    usart_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .sync_mode_select(sync_mode_select),
        .double_speed(double_speed), .xfer_clock_pin_dir(xfer_clock_pin_dir),
        .sync_clock_polarity(sync_clock_polarity), .frame_cfg(frame_cfg),
        .baud_divisor_high(baud_divisor_high), .baud_divisor_low(baud_divisor_low),
        .baud_low_wr(baud_low_wr), .tx_data(tx_data), .ninth_tx_bit(ninth_tx_bit), .tx_wr(tx_wr),
        .tx_buf_empty(tx_buf_empty), .tx_done(tx_done), .rx_rd(rx_rd), .rx_data(rx_data),
        .rx_valid(rx_valid), .frame_error_flag(frame_error_flag),
        .parity_error_flag(parity_error_flag), .overrun_flag(overrun_flag),
        .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin),
        .transfer_clock_pin_in(transfer_clock_pin_in),
        .transfer_clock_pin_out(transfer_clock_pin_out),
        .transfer_clock_pin_oe(transfer_clock_pin_oe));
    usart_remote remote (.sys_clk(sys_clk), .bit_cyc(bit_cyc), .nbits(nbits),
        .par_en(frame_cfg.parity_mode_sel[1]), .stop2(frame_cfg.stop_bits_sel),
        .sync_on(sync_mode_select), .pol(sync_clock_polarity),
        .xck_in(transfer_clock_pin_out),
        .line_in(serial_tx_pin), .line_out(serial_rx_pin), .got_frame(got_frame),
        .got_valid(got_valid));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic par_of(input logic [8:0] d);
        return frame_cfg.parity_mode_sel[1] & (^d ^ frame_cfg.parity_mode_sel[0]);
    endfunction
    task automatic put_tx;
        logic [8:0] d;
        int n;
        d = 9'($random(seed));
        n = 0;
        while (tx_buf_empty !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        tx_data = d[7:0];
        ninth_tx_bit = d[8];
        tx_wr = 1'b1;
        d = d & (9'h1FF >> (9 - nbits));
        tx_exp.push_back({1'b1, par_of(d), d});
        @(negedge sys_clk);
        tx_wr = 1'b0;
    endtask
    task automatic rx_frame(input logic bad_par, input logic stop, input logic keep);
        logic [8:0] d;
        d = 9'($random(seed)) & (9'h1FF >> (9 - nbits));
        if (keep) begin
            rx_exp.push_back({~stop, frame_cfg.parity_mode_sel[1] & bad_par, d});
        end
        remote.send(d, par_of(d) ^ bad_par, stop);
    endtask
    task automatic drain(input int done_exp);
        int n;
        int d;
        n = 0;
        d = 0;
        while ((tx_exp.size() > 0 || rx_exp.size() > 0) && n < 3000) begin
            @(negedge sys_clk);
            n++;
            d += int'(tx_done === 1'b1);
        end
        if (n == 3000) check(11'h000, 11'h001, "queue drain");
        repeat (3 * bit_cyc) begin
            @(negedge sys_clk);
            d += int'(tx_done === 1'b1);
        end
        check(11'(d), 11'(done_exp), "tx done pulses");
    endtask
    initial begin
        forever begin
            @(negedge sys_clk);
            if (got_valid === 1'b1) begin
                e = tx_exp.size() > 0 ? tx_exp.pop_front() : ~got_frame;
                check(got_frame, e, "tx frame");
            end
        end
    end
    initial begin
        rx_rd = 1'b0;
        forever begin
            @(negedge sys_clk);
            if (rx_valid === 1'b1 && !hold_rd) begin
                e = rx_exp.size() > 0 ? rx_exp.pop_front() : 11'h7FF;
                check({frame_error_flag, parity_error_flag, rx_data}, e, "rx entry");
                rx_rd = 1'b1;
                @(negedge sys_clk);
                rx_rd = 1'b0;
                @(negedge sys_clk);
            end
        end
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        failures++;
        $display("MISMATCH at %0t: run timed out", $time);
        give_verdict();
    end
    initial begin
        seed = 54126;
        failures = 0;
        cmp_count = 0;
        hold_rd = 1'b0;
        rst_b = 1'b0;
        {sync_mode_select, double_speed, xfer_clock_pin_dir, sync_clock_polarity} = 4'h0;
        transfer_clock_pin_in = 1'b0;
        frame_cfg = '{3'h3, 2'h0, 1'b0};
        nbits = 8;
        bit_cyc = 32;
        baud_divisor_high = 4'h0;
        baud_divisor_low = 8'h02;
        {baud_low_wr, tx_wr, ninth_tx_bit, tx_data} = 11'h000;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        check({10'h000, tx_buf_empty}, 11'h001, "empty after reset");
        baud_low_wr = 1'b1;
        @(negedge sys_clk);
        baud_low_wr = 1'b0;
        for (i = 0; i < 4; i++) begin
            sync_mode_select = i[1];
            xfer_clock_pin_dir = i[0];
            repeat (3) @(negedge sys_clk);
            check({10'h000, transfer_clock_pin_oe}, {10'h000, i[1] & i[0]}, "pin enable");
            k = 0;
            for (j = 0; j < 30; j++) begin
                // slave clock of eight cycles, well under a quarter of sys_clk
                if (i == 2) transfer_clock_pin_in = j[2];
                prev = transfer_clock_pin_out;
                @(negedge sys_clk);
                if (transfer_clock_pin_out !== prev) k++;
            end
            check(11'(k), (i == 3) ? 11'h00A : 11'h000, "clock edges");
        end
        {sync_mode_select, xfer_clock_pin_dir} = 2'h0;
        baud_divisor_low = 8'h01;
        baud_low_wr = 1'b1;
        @(negedge sys_clk);
        baud_low_wr = 1'b0;
        for (ds = 0; ds < 2; ds++) for (s = 0; s < 5; s++) for (p = 0; p < 3; p++)
            for (sp = 0; sp < 2; sp++) begin
                double_speed = ds[0];
                frame_cfg = '{sizes[s], pars[p], sp[0]};
                nbits = (s == 4) ? 9 : s + 5;
                bit_cyc = ds ? 16 : 32;
                repeat (2) @(negedge sys_clk);
                fork
                    begin
                        put_tx();
                        put_tx();
                    end
                    rx_frame(1'b0, 1'b1, 1'b1);
                join
                drain(1);
            end
        // synchronous master transfers in both clock polarities
        {sync_mode_select, xfer_clock_pin_dir, double_speed} = 3'h6;
        bit_cyc = 4;
        for (p = 0; p < 2; p++) begin
            sync_clock_polarity = p[0];
            repeat (2) @(negedge sys_clk);
            fork
                begin
                    put_tx();
                    put_tx();
                end
                rx_frame(1'b0, 1'b1, 1'b1);
            join
            drain(1);
        end
        {sync_mode_select, xfer_clock_pin_dir, sync_clock_polarity} = 3'h0;
        double_speed = 1'b0;
        frame_cfg = '{3'h3, 2'h2, 1'b0};
        nbits = 8;
        bit_cyc = 32;
        rx_frame(1'b1, 1'b1, 1'b1);
        rx_frame(1'b0, 1'b0, 1'b1);
        drain(0);
        hold_rd = 1'b1;
        for (i = 0; i < 3; i++) rx_frame(1'b0, 1'b1, i < 2);
        repeat (4) @(negedge sys_clk);
        check({9'h000, rx_valid, overrun_flag}, 11'h003, "overrun set");
        hold_rd = 1'b0;
        drain(0);
        check({10'h000, overrun_flag}, 11'h000, "overrun cleared");
        give_verdict();
    end
endmodule // test_usart_core

// [verif/usart_remote.sv]
`timescale 1ns/1ns
module usart_remote (
    // clock and frame settings
    input wire logic sys_clk,
    input wire integer bit_cyc,
    input wire integer nbits,
    input wire logic par_en,
    input wire logic stop2,
    // synchronous clocking seen on the line
    input wire logic sync_on,
    input wire logic pol,
    input wire logic xck_in,
    // serial line
    input wire logic line_in,
    output logic line_out,
    // decoded frame {stop, parity, data}
    output logic [10:0] got_frame,
    output logic got_valid
);
    initial begin
        line_out = 1'b1;
        got_frame = 11'h000;
        got_valid = 1'b0;
    end
    task automatic hold_bit(input logic v);
        line_out = v;
        repeat (bit_cyc) @(negedge sys_clk);
    endtask
    // one frame toward the receiver, first stop level chosen by the caller
    task automatic send(input logic [8:0] d, input logic p, input logic s);
        int i;
        // in synchronous mode change data just after the change edge
        if (sync_on) begin
            @(xck_in);
            if (xck_in == pol) @(xck_in);
        end
        @(negedge sys_clk);
        hold_bit(1'b0);
        for (i = 0; i < nbits; i++) begin
            hold_bit(d[i]);
        end
        if (par_en) begin
            hold_bit(p);
        end
        hold_bit(s);
        if (stop2) begin
            hold_bit(1'b1);
        end
        hold_bit(1'b1);
    endtask
    // samples data, parity and first stop bit of the transmitted frame in mid-bit
    always begin : decode
        int i;
        @(negedge line_in);
        got_frame = 11'h000;
        repeat (bit_cyc / 2) @(posedge sys_clk);
        for (i = 0; i < nbits; i++) begin
            repeat (bit_cyc) @(posedge sys_clk);
            got_frame[i] = line_in;
        end
        if (par_en) begin
            repeat (bit_cyc) @(posedge sys_clk);
            got_frame[9] = line_in;
        end
        repeat (bit_cyc) @(posedge sys_clk);
        got_frame[10] = line_in;
        got_valid = 1'b1;
        @(posedge sys_clk);
        got_valid = 1'b0;
    end
endmodule // usart_remote
